//--- dtb_mask_tester.sv
`timescale 1ns/1ps
module dtb_mask_tester
   import dtb_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rstn_i,
   dtb_tm_if.rsp     tm
);
   import dtb_pkg::*;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tm.valid <= 1'b0;
         tm.cc    <= CC_RESET;
      end else begin
         tm.valid <= tm.start;
         if (tm.start) begin
            tm.cc <= dtb_mask_cc(tm.mask, tm.data);
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_cc_zero_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tm.start && ((tm.mask & tm.data) == 16'h0000) |=> tm.valid && tm.cc == 2'b00)
      else $error("cc not 00 for zero selection");
   chk_cc_mixed_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tm.start && ((tm.mask & tm.data) != 16'h0000) && ((tm.mask & tm.data) != tm.mask)
      |=> tm.cc == 2'b01)
      else $error("cc not 01 for mixed selection");
   chk_cc_ones_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tm.start && (tm.mask != 16'h0000) && ((tm.mask & tm.data) == tm.mask) |=> tm.cc == 2'b11)
      else $error("cc not 11 for all ones");
endmodule // dtb_mask_tester

//--- dtb_order_exec.sv
`timescale 1ns/1ps
module dtb_order_exec
   import dtb_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        start_i,
   input  wire logic [15:0] start_addr_i,
   output logic             buf_req_o,
   output logic             buf_we_o,
   output logic [15:0]      buf_addr_o,
   output logic [15:0]      buf_wdata_o,
   input  wire logic        buf_ack_i,
   input  wire logic [15:0] buf_rdata_i,
   output logic             done_o,
   output logic             branch_o,
   output logic             illegal_o,
   output logic [15:0]      next_addr_o,
   output logic [1:0]       cc_o
);
   import dtb_pkg::*;

   dtb_state_t  state;
   logic [15:0] pc;
   logic [15:0] code;
   logic [15:0] target;
   logic [15:0] arg;
   logic        tm_start;
   logic [15:0] tm_data;

   // Anything else is refused after its three words are read, without a write to the buffer
   function automatic logic dtb_known_order(input logic [15:0] word);
      dtb_known_order = (word == TUM_CODE) || (word == CBR_CODE);
   endfunction

   dtb_tm_if tm_bus ();
   assign tm_bus.start = tm_start;
   assign tm_bus.mask  = arg;
   assign tm_bus.data  = tm_data;

   dtb_mask_tester i_dtb_mask_tester (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .tm     (tm_bus.rsp)
   );

   // ****************************************
   // Order sequencer and buffer port
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state       <= ST_IDLE;
         pc          <= 16'h0000;
         code        <= 16'h0000;
         target      <= 16'h0000;
         arg         <= 16'h0000;
         tm_start    <= 1'b0;
         tm_data     <= 16'h0000;
         buf_req_o   <= 1'b0;
         buf_we_o    <= 1'b0;
         buf_addr_o  <= 16'h0000;
         buf_wdata_o <= 16'h0000;
      end else begin
         tm_start <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (start_i) begin
                  pc         <= start_addr_i;
                  buf_addr_o <= start_addr_i;
                  buf_req_o  <= 1'b1;
                  state      <= ST_CODE;
               end
            end
            ST_CODE: begin
               if (buf_ack_i) begin
                  code       <= buf_rdata_i;
                  buf_addr_o <= pc + ADDR_OFS;
                  state      <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               if (buf_ack_i) begin
                  target     <= buf_rdata_i;
                  buf_addr_o <= pc + ARG_OFS;
                  state      <= ST_ARG;
               end
            end
            ST_ARG: begin
               if (buf_ack_i) begin
                  arg <= buf_rdata_i;
                  if (code == TUM_CODE) begin
                     buf_addr_o <= target;
                     state      <= ST_OPND;
                  end else if (code == CBR_CODE) begin
                     // Count lives in the order itself, so rewrite the same word
                     buf_we_o    <= 1'b1;
                     buf_wdata_o <= buf_rdata_i - 16'h0001;
                     state       <= ST_WRITE;
                  end else begin
                     buf_req_o <= 1'b0;
                     state     <= ST_IDLE;
                  end
               end
            end
            ST_OPND: begin
               if (buf_ack_i) begin
                  buf_req_o <= 1'b0;
                  tm_data   <= buf_rdata_i;
                  tm_start  <= 1'b1;
                  state     <= ST_EVAL;
               end
            end
            ST_EVAL: begin
               if (tm_bus.valid) begin
                  state <= ST_IDLE;
               end
            end
            ST_WRITE: begin
               if (buf_ack_i) begin
                  buf_req_o <= 1'b0;
                  buf_we_o  <= 1'b0;
                  state     <= ST_IDLE;
               end
            end
            default: begin
               buf_req_o <= 1'b0;
               buf_we_o  <= 1'b0;
               state     <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Condition code
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cc_o <= CC_RESET;
      end else if (state == ST_EVAL && tm_bus.valid) begin
         cc_o <= tm_bus.cc;
      end
   end

   // ****************************************
   // Completion and successor address
   // ****************************************
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_o      <= 1'b0;
         branch_o    <= 1'b0;
         illegal_o   <= 1'b0;
         next_addr_o <= 16'h0000;
      end else begin
         done_o    <= 1'b0;
         branch_o  <= 1'b0;
         illegal_o <= 1'b0;
         if (state == ST_ARG && buf_ack_i && !dtb_known_order(code)) begin
            done_o      <= 1'b1;
            illegal_o   <= 1'b1;
            next_addr_o <= pc + ORDER_LEN;
         end else if (state == ST_EVAL && tm_bus.valid) begin
            done_o      <= 1'b1;
            next_addr_o <= pc + ORDER_LEN;
         end else if (state == ST_WRITE && buf_ack_i) begin
            done_o <= 1'b1;
            if (buf_wdata_o != 16'h0000) begin
               branch_o    <= 1'b1;
               next_addr_o <= target;
            end else begin
               next_addr_o <= pc + ORDER_LEN;
            end
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_arg_taken;
      state == ST_ARG && buf_ack_i;
   endsequence

   sequence s_count_done;
      state == ST_WRITE && buf_ack_i;
   endsequence

   chk_cc_no_ten: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cc_o != 2'b10)
      else $error("condition code 10 produced");
   chk_count_decrement: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_arg_taken and (code == CBR_CODE)
      |=> buf_we_o && buf_wdata_o == $past(buf_rdata_i) - 16'h0001
      && buf_addr_o == pc + ARG_OFS)
      else $error("count not decremented in place");
   chk_count_wrap: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_arg_taken and (code == CBR_CODE) and (buf_rdata_i == 16'h0000)
      |=> buf_wdata_o == ALL_ONES ##[1:300] (done_o && branch_o))
      else $error("zero count did not wrap and branch");
   chk_branch_pick: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_count_done |=> done_o && (branch_o == ($past(buf_wdata_o) != 16'h0000))
      && next_addr_o == (branch_o ? target : pc + ORDER_LEN))
      else $error("wrong successor after count order");
   chk_cc_kept_count: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_count_done |=> $stable(cc_o))
      else $error("count order changed condition code");
   chk_tum_operand: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_arg_taken and (code == TUM_CODE)
      |=> state == ST_OPND && buf_addr_o == target && !buf_we_o)
      else $error("mask order operand fetch wrong");
   chk_tum_one_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state == ST_OPND && buf_ack_i |=> !buf_req_o ##1 !buf_req_o)
      else $error("mask order touched more than one word");
   chk_cc_update: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state == ST_EVAL && tm_bus.valid
      |=> cc_o == dtb_mask_cc($past(arg), $past(tm_data)) && done_o)
      else $error("condition code not taken from test");
   chk_unknown_refused: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_arg_taken and (!dtb_known_order(code))
      |=> !buf_req_o && !buf_we_o && done_o && illegal_o && $stable(cc_o))
      else $error("unknown order not refused");
endmodule // dtb_order_exec

//--- dtb_pkg.sv
package dtb_pkg;
   localparam logic [15:0] TUM_CODE   = 16'h2AED;
   localparam logic [15:0] CBR_CODE   = 16'h2AF0;
   localparam logic [15:0] ADDR_OFS   = 16'h0002;
   localparam logic [15:0] ARG_OFS    = 16'h0004;
   localparam logic [15:0] ORDER_LEN  = 16'h0006;
   localparam logic [15:0] ALL_ONES   = 16'hFFFF;
   localparam logic [1:0]  CC_RESET   = 2'h0;
   localparam logic [1:0]  CC_ZERO    = 2'h0;
   localparam logic [1:0]  CC_MIXED   = 2'h1;
   localparam logic [1:0]  CC_UNUSED  = 2'h2;
   localparam logic [1:0]  CC_ONES    = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CODE  = 3'b001,
      ST_ADDR  = 3'b010,
      ST_ARG   = 3'b011,
      ST_OPND  = 3'b100,
      ST_EVAL  = 3'b101,
      ST_WRITE = 3'b110
   } dtb_state_t;

   function automatic logic [1:0] dtb_mask_cc(input logic [15:0] mask, input logic [15:0] data);
      logic [15:0] sel;
      sel = mask & data;
      if (sel == 16'h0000) dtb_mask_cc = CC_ZERO;
      else if (sel == mask) dtb_mask_cc = CC_ONES;
      else dtb_mask_cc = CC_MIXED;
   endfunction
endpackage

//--- dtb_tm_if.sv
`timescale 1ns/1ps
interface dtb_tm_if;
   logic        start;
   logic [15:0] mask;
   logic [15:0] data;
   logic        valid;
   logic [1:0]  cc;
   modport req (output start, output mask, output data, input valid, input cc);
   modport rsp (input start, input mask, input data, output valid, output cc);
endinterface

//--- tb_display_test_and_count_branch_orders.sv
`timescale 1ns/1ps
module tb_display_test_and_count_branch_orders;
   import dtb_pkg::*;
   logic        clk_i, rstn_i, start_i, buf_ack_i, slow, tog;
   logic [15:0] start_addr_i, buf_rdata_i, got_next, mem [0:255];
   logic        buf_req_o, buf_we_o, done_o, branch_o, illegal_o, got_br, got_ill;
   logic [15:0] buf_addr_o, buf_wdata_o, next_addr_o;
   logic [1:0]  cc_o;
   int          err_count, samples_checked, n_rd, n_wr;

   dtb_order_exec i_dtb_order_exec (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
      .start_addr_i(start_addr_i), .buf_req_o(buf_req_o), .buf_we_o(buf_we_o),
      .buf_addr_o(buf_addr_o), .buf_wdata_o(buf_wdata_o), .buf_ack_i(buf_ack_i),
      .buf_rdata_i(buf_rdata_i), .done_o(done_o), .branch_o(branch_o),
      .illegal_o(illegal_o), .next_addr_o(next_addr_o), .cc_o(cc_o));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ****************************************
   // Buffer memory, optional wait states
   // ****************************************
   // Unacked cycles show inverted data so stale reads cannot match
   always @(posedge clk_i) begin
      if (buf_req_o && buf_ack_i) begin
         if (buf_we_o) begin
            n_wr++;
            mem[buf_addr_o[8:1]] <= buf_wdata_o;
         end else n_rd++;
      end
      #1;
      tog = ~tog;
      buf_ack_i = buf_req_o && (!slow || tog);
      buf_rdata_i = buf_ack_i ? mem[buf_addr_o[8:1]] : ~mem[buf_addr_o[8:1]];
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic run(input logic [15:0] pc);
      int i;
      logic seen;
      seen = 1'b0;
      n_rd = 0;
      n_wr = 0;
      start_addr_i = pc;
      start_i = 1'b1;
      @(posedge clk_i);
      #1;
      start_i = 1'b0;
      for (i = 0; i < 100 && !seen; i++) begin
         @(posedge clk_i);
         #1;
         if (done_o === 1'b1) begin
            seen = 1'b1;
            got_br = branch_o;
            got_ill = illegal_o;
            got_next = next_addr_o;
         end
      end
      if (!seen) begin
         err_count++;
         $display("FAIL done expected 1 seen 0");
         test_done();
      end else begin
         @(posedge clk_i);
         #1;
         chk("done pulse", 16'h0000, {15'h0000, done_o});
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_mask();
      logic [15:0] tab [0:6][0:2] = '{'{16'h0000, 16'hFFFF, 16'h0000},
         '{16'h00F0, 16'h0F0F, 16'h0000}, '{16'h00F0, 16'h0070, 16'h0001},
         '{16'hFFFF, 16'hFFFF, 16'h0003}, '{16'h8001, 16'h8001, 16'h0003},
         '{16'h8000, 16'h7FFF, 16'h0000}, '{16'hFFFF, 16'h0001, 16'h0001}};
      for (int i = 0; i < 7; i++) begin
         slow = (i == 3);
         mem[8'h08] = TUM_CODE;
         mem[8'h09] = 16'h0040;
         mem[8'h0A] = tab[i][0];
         mem[8'h20] = tab[i][1];
         run(16'h0010);
         chk("mask cc", tab[i][2], {14'h0000, cc_o});
         chk("cc ten", 16'h0000, {15'h0000, cc_o === CC_UNUSED});
         chk("mask reads", 16'h0004, n_rd[15:0]);
         chk("mask writes", 16'h0000, n_wr[15:0]);
         chk("mask next", 16'h0016, got_next);
         chk("mask flags", 16'h0000, {14'h0000, got_br, got_ill});
      end
      slow = 1'b0;
   endtask

   task automatic t_count();
      logic [15:0] exp_cnt [0:2] = '{16'h0001, 16'h0000, 16'hFFFF};
      mem[8'h30] = CBR_CODE;
      mem[8'h31] = 16'h0100;
      mem[8'h32] = 16'h0002;
      for (int i = 0; i < 3; i++) begin
         slow = (i == 1);
         run(16'h0060);
         chk("count value", exp_cnt[i], mem[8'h32]);
         chk("count writes", 16'h0001, n_wr[15:0]);
         chk("count branch", {15'h0000, exp_cnt[i] != 16'h0000}, {15'h0000, got_br});
         chk("count next", (exp_cnt[i] != 16'h0000) ? 16'h0100 : 16'h0066, got_next);
         chk("count cc kept", 16'h0001, {14'h0000, cc_o});
      end
      slow = 1'b0;
   endtask

   task automatic t_illegal();
      mem[8'h40] = 16'h1234;
      run(16'h0080);
      chk("illegal flag", 16'h0001, {15'h0000, got_ill});
      chk("illegal writes", 16'h0000, n_wr[15:0]);
      chk("illegal next", 16'h0086, got_next);
      chk("illegal cc kept", 16'h0001, {14'h0000, cc_o});
   endtask

   // Reset cuts a count order before its write-back, then the order reruns
   task automatic t_reset();
      start_addr_i = 16'h0060;
      start_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      start_i = 1'b0;
      rstn_i = 1'b0;
      #1;
      chk("reset outputs", 16'h0000, {12'h000, buf_req_o, buf_we_o, done_o, branch_o});
      chk("reset cc mid", {14'h0000, CC_RESET}, {14'h0000, cc_o});
      @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      run(16'h0060);
      chk("rerun count", 16'hFFFE, mem[8'h32]);
      chk("rerun branch", 16'h0100, got_next);
      chk("rerun cc kept", {14'h0000, CC_RESET}, {14'h0000, cc_o});
   endtask

   initial begin
      rstn_i = 1'b0;
      start_i = 1'b0;
      start_addr_i = 16'h0000;
      buf_ack_i = 1'b0;
      buf_rdata_i = 16'h0000;
      slow = 1'b0;
      tog = 1'b0;
      err_count = 0;
      samples_checked = 0;
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
      repeat (3) @(posedge clk_i);
      #1;
      rstn_i = 1'b1;
      chk("reset cc", {14'h0000, CC_RESET}, {14'h0000, cc_o});
      t_mask();
      t_count();
      t_illegal();
      t_reset();
      test_done();
   end
endmodule // tb_display_test_and_count_branch_orders
